// ---- pkg/vem_pkg.sv ----
package vem_pkg;
  // Envelope stages, Gray coded along attack, decay and release path
  typedef enum logic [2:0] {
    VEM_IDLE = 3'h0,
    VEM_ATK1 = 3'h1,
    VEM_ATK2 = 3'h3,
    VEM_DCY1 = 3'h2,
    VEM_DCY2 = 3'h6,
    VEM_REL1 = 3'h7,
    VEM_REL2 = 3'h5
  } vem_stage_t;

  // Widths
  localparam int RATE_W     = 7;
  localparam int LVL_W      = 8;
  localparam int LVL_FRAC_W = 8;
  localparam int OUT_W      = LVL_W + LVL_FRAC_W;
  localparam int NUM_STG    = 6;
  localparam int CNT_W      = 19;
  localparam int PH_W       = 16;
  localparam int ENV_MANT_W = 3;
  localparam int FLD_STRIDE = 8;
  localparam int NUM_LFO    = 2;

  // Control tick and time figures
  localparam int CTRL_TICK_HZ   = 1000;
  localparam int ENV_TIME_MIN_MS = 1;
  localparam int ENV_TIME_MAX_S  = 160;
  localparam int ENV_TIME_SHR   = 2;
  localparam int ENV_TEMPO_UNIT = 12;
  localparam int TEMPO_PPQ      = 48;
  localparam int DLY_ABS_TICKS  = 16;

  // Absolute oscillator rate span in millihertz, mapped to phase steps
  localparam longint LFO_MHZ_MIN = 80;
  localparam longint LFO_MHZ_MAX = 18140;
  localparam int LFO_INC_BASE = int'((LFO_MHZ_MIN * 65536) / (CTRL_TICK_HZ * 1000));
  localparam int LFO_SLOPE_Q2 =
    int'(((LFO_MHZ_MAX - LFO_MHZ_MIN) * 65536 * 4) / (CTRL_TICK_HZ * 1000 * 127));
  localparam int LFO_RATE_MAX = 127;
  localparam int NOTE_LAST    = 24;
  localparam int VAR_MAX      = 100;
  localparam int VAR_SHR      = 15;

  // Phase step per tempo tick, slowest note first
  localparam logic [15:0] NOTE_INC [0:24] = '{
    16'h002B, 16'h0039, 16'h0040, 16'h0055, 16'h0072, 16'h0080, 16'h00AB,
    16'h00E4, 16'h0100, 16'h0155, 16'h01C7, 16'h0200, 16'h02AB, 16'h038E,
    16'h0400, 16'h0555, 16'h071C, 16'h0800, 16'h0AAB, 16'h0E39, 16'h1000,
    16'h1555, 16'h1C72, 16'h2000, 16'h2AAB};
  // Note lengths in tempo ticks, same order
  localparam logic [15:0] NOTE_LEN [0:24] = '{
    16'h0600, 16'h0480, 16'h0400, 16'h0300, 16'h0240, 16'h0200, 16'h0180,
    16'h0120, 16'h0100, 16'h00C0, 16'h0090, 16'h0080, 16'h0060, 16'h0048,
    16'h0040, 16'h0030, 16'h0024, 16'h0020, 16'h0018, 16'h0012, 16'h0010,
    16'h000C, 16'h0009, 16'h0008, 16'h0006};
  localparam logic [7:0] PAT_STEP [0:7] = '{
    8'h00, 8'h20, 8'h40, 8'h60, 8'h40, 8'h20, 8'hE0, 8'hC0};

  // Waveform shapes
  localparam logic [2:0] SHP_TRI  = 3'h0;
  localparam logic [2:0] SHP_SQR  = 3'h1;
  localparam logic [2:0] SHP_SAWU = 3'h2;
  localparam logic [2:0] SHP_SAWD = 3'h3;
  localparam logic [2:0] SHP_RND  = 3'h4;
  localparam logic [2:0] SHP_PAT  = 3'h5;

  // Register word indices and fields
  localparam logic [3:0] REG_FENV   = 4'h0;
  localparam logic [3:0] REG_AENV   = 4'h4;
  localparam logic [3:0] REG_LFO1   = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hA;
  localparam int NUM_CFG        = 10;
  localparam int ENV_MODE_BIT   = 16;
  localparam int ENV_REPEAT_BIT = 17;
  localparam int LFO_SYNC_BIT   = 3;
  localparam int LFO_RATE_LSB   = 8;
  localparam int LFO_DLY_LSB    = 16;
  localparam int LFO_VAR_LSB    = 24;
  localparam int STAT_AENV_LSB  = 4;
  localparam int STAT_LFO_LSB   = 8;
  localparam logic [31:0] CFG_MASK [0:9] = '{
    32'h7F7F7F7F, 32'h00037F7F, 32'hFFFFFFFF, 32'h0000FFFF,
    32'h7F7F7F7F, 32'h00037F7F, 32'hFFFFFFFF, 32'h0000FFFF,
    32'h7FFFFF0F, 32'h7FFFFF0F};
  localparam logic [31:0] CFG_RST [0:9] = '{
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000008, 32'h00000008};
endpackage : vem_pkg

// ---- hdl/vem_env.sv ----
`timescale 1ns/1ps
`default_nettype none
module vem_env
  import vem_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     ce_i,
  input  wire logic                     tick_i,
  input  wire logic                     tempo_tick_i,
  input  wire logic                     key_on_i,
  input  wire logic                     key_off_i,
  input  wire logic [NUM_STG*RATE_W-1:0] rates_i,
  input  wire logic [NUM_STG*LVL_W-1:0]  levels_i,
  input  wire logic                     tempo_mode_i,
  input  wire logic                     repeat_i,
  output logic      [OUT_W-1:0]         level_o,
  output logic                          hold_o,
  output vem_stage_t                    stage_o
);
  vem_stage_t               stage_ff;
  vem_stage_t               nxt_stage;
  logic                     hold_ff;
  logic signed [OUT_W-1:0]  level_ff;
  logic signed [OUT_W:0]    step_ff;
  logic        [CNT_W-1:0]  cnt_ff;
  logic                     adv;
  logic                     enter;
  logic                     natural;
  logic                     fin;
  logic signed [OUT_W-1:0]  cur_tgt;
  logic signed [OUT_W-1:0]  ent_tgt;
  logic signed [OUT_W-1:0]  base;
  logic        [CNT_W-1:0]  ent_dur;
  logic signed [OUT_W:0]    ent_step;

  function automatic int sidx(input vem_stage_t s);
    case (s)
      VEM_ATK2: sidx = 1;
      VEM_DCY1: sidx = 2;
      VEM_DCY2: sidx = 3;
      VEM_REL1: sidx = 4;
      VEM_REL2: sidx = 5;
      default:  sidx = 0;
    endcase
  endfunction : sidx

  // Time mode is exponential in the rate; tempo mode counts tempo ticks
  function automatic logic [CNT_W-1:0] stage_dur(input logic [RATE_W-1:0] r,
                                                 input logic tm);
    logic [CNT_W-1:0] d;
    d = '0;
    if (tm) begin
      d = CNT_W'(r) * CNT_W'(ENV_TEMPO_UNIT);
    end else begin
      d = (CNT_W'({1'b1, r[ENV_MANT_W-1:0]}) << r[RATE_W-1:ENV_MANT_W]) >> ENV_TIME_SHR;
    end
    if (d == '0) begin
      d = CNT_W'(1);
    end
    return d;
  endfunction : stage_dur

  // Smallest power of two not below the duration, so rising steps never overshoot
  function automatic logic [4:0] clog(input logic [CNT_W-1:0] d);
    logic [4:0] c;
    c = '0;
    for (int i = 0; i < CNT_W; i++) begin
      if (d > (CNT_W'(1) << i)) begin
        c = 5'(i + 1);
      end
    end
    return c;
  endfunction : clog

  assign adv     = tempo_mode_i ? tempo_tick_i : tick_i;
  assign cur_tgt = signed'({levels_i[sidx(stage_ff)*LVL_W +: LVL_W], {LVL_FRAC_W{1'b0}}});
  assign ent_tgt = signed'({levels_i[sidx(nxt_stage)*LVL_W +: LVL_W], {LVL_FRAC_W{1'b0}}});
  assign base    = natural ? cur_tgt : level_ff;
  assign ent_dur = stage_dur(rates_i[sidx(nxt_stage)*RATE_W +: RATE_W], tempo_mode_i);
  assign ent_step = ((OUT_W+1)'(ent_tgt) - (OUT_W+1)'(base)) >>> clog(ent_dur);

  // Stage sequencing decision
  always_comb begin
    nxt_stage = stage_ff;
    enter     = 1'b0;
    natural   = 1'b0;
    fin       = 1'b0;
    if (key_on_i) begin
      nxt_stage = VEM_ATK1;
      enter     = 1'b1;
    end else if (key_off_i && stage_ff != VEM_IDLE && stage_ff != VEM_REL1 &&
                 stage_ff != VEM_REL2) begin
      nxt_stage = VEM_REL1;
      enter     = 1'b1;
    end else if (adv && !hold_ff && stage_ff != VEM_IDLE && cnt_ff == CNT_W'(1)) begin
      case (stage_ff)
        VEM_ATK1: nxt_stage = VEM_ATK2;
        VEM_ATK2: nxt_stage = VEM_DCY1;
        VEM_DCY1: nxt_stage = VEM_DCY2;
        VEM_DCY2: if (repeat_i) nxt_stage = VEM_ATK1; else fin = 1'b1;
        VEM_REL1: nxt_stage = VEM_REL2;
        default:  fin = 1'b1;
      endcase
      natural = !fin;
      enter   = !fin;
    end
  end

  // Stage, counter and slope
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_ff <= VEM_IDLE;
      hold_ff  <= 1'b0;
      cnt_ff   <= '0;
      step_ff  <= '0;
    end else if (ce_i) begin
      if (enter) begin
        stage_ff <= nxt_stage;
        cnt_ff   <= ent_dur;
        step_ff  <= ent_step;
        hold_ff  <= 1'b0;
      end else if (fin) begin
        hold_ff <= 1'b1;
      end else if (adv && !hold_ff && stage_ff != VEM_IDLE) begin
        cnt_ff <= cnt_ff - CNT_W'(1);
      end
    end
  end

  // Level ramps linearly and snaps to the target at each timed stage end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_ff <= '0;
    end else if (ce_i) begin
      if (enter) begin
        level_ff <= base;
      end else if (fin) begin
        level_ff <= cur_tgt;
      end else if (adv && !hold_ff && stage_ff != VEM_IDLE) begin
        level_ff <= level_ff + step_ff[OUT_W-1:0];
      end
    end
  end

  assign level_o = level_ff;
  assign hold_o  = hold_ff;
  assign stage_o = stage_ff;
endmodule : vem_env
`default_nettype wire

// ---- hdl/vem_voice_mod.sv ----
`timescale 1ns/1ps
`default_nettype none
module vem_voice_mod
  import vem_pkg::*;
#(
  parameter logic [31:0] LFSR_SEED = 32'h5A3C_96E1
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             tick_i,
  input  wire logic             tempo_tick_i,
  input  wire logic             key_on_i,
  input  wire logic             key_off_i,
  input  wire logic [7:0]       lfo1_rate_mod_i,
  input  wire logic [7:0]       lfo2_rate_mod_i,
  input  wire logic [3:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             we_i,
  input  wire logic             re_i,
  output logic      [31:0]      rdata_o,
  output logic      [OUT_W-1:0] fenv_o,
  output logic      [OUT_W-1:0] aenv_o,
  output logic      [OUT_W-1:0] lfo1_o,
  output logic      [OUT_W-1:0] lfo2_o
);
  logic [31:0]              cfg_ff [0:NUM_CFG-1];
  logic [31:0]              rdata_ff;
  logic [31:0]              status;
  logic [31:0]              lfsr_ff;
  logic [NUM_STG*RATE_W-1:0] env_rates [0:1];
  logic [NUM_STG*LVL_W-1:0]  env_lvls  [0:1];
  logic [OUT_W-1:0]         env_lvl   [0:1];
  logic                     env_hold  [0:1];
  vem_stage_t               env_stage [0:1];
  logic [OUT_W-1:0]         lfo_ff    [0:NUM_LFO-1];
  logic [NUM_LFO-1:0]       lfo_act;
  logic [7:0]               rate_mod  [0:NUM_LFO-1];

  assign rate_mod[0] = lfo1_rate_mod_i;
  assign rate_mod[1] = lfo2_rate_mod_i;

  // Configuration words; reserved bits are masked so they read zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < NUM_CFG; k++) begin
        cfg_ff[k] <= CFG_RST[k];
      end
    end else if (ce_i && we_i) begin
      for (int k = 0; k < NUM_CFG; k++) begin
        if (addr_i == 4'(k)) begin
          cfg_ff[k] <= wdata_i & CFG_MASK[k];
        end
      end
    end
  end

  // Status word shows live stages, hold flags and oscillator activity
  always_comb begin
    status = '0;
    status[STAT_AENV_LSB-2:0] = env_stage[0];
    status[STAT_AENV_LSB-1] = env_hold[0];
    status[STAT_AENV_LSB +: 3] = env_stage[1];
    status[STAT_AENV_LSB+3] = env_hold[1];
    status[STAT_LFO_LSB +: NUM_LFO] = lfo_act;
  end

  // Read data stands one cycle only; unmapped words read zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
    end else if (ce_i) begin
      if (!re_i) begin
        rdata_ff <= '0;
      end else if (addr_i < 4'(NUM_CFG)) begin
        rdata_ff <= cfg_ff[addr_i];
      end else if (addr_i == REG_STATUS) begin
        rdata_ff <= status;
      end else begin
        rdata_ff <= '0;
      end
    end
  end
  assign rdata_o = rdata_ff;

  // Per-voice random source; the seed differs per instance
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lfsr_ff <= LFSR_SEED;
    end else if (ce_i) begin
      lfsr_ff <= {lfsr_ff[30:0], 1'b0} ^ (lfsr_ff[31] ? 32'h04C1_1DB7 : 32'h0);
    end
  end

  // Both envelopes: rate and level fields unpacked from two words each
  for (genvar e = 0; e < 2; e++) begin : g_env
    localparam logic [3:0] BASE = e ? REG_AENV : REG_FENV;
    always_comb begin
      env_rates[e] = '0;
      env_lvls[e]  = '0;
      for (int k = 0; k < NUM_STG; k++) begin
        env_rates[e][k*RATE_W +: RATE_W] =
          cfg_ff[BASE + 4'(k / 4)][(k % 4)*FLD_STRIDE +: RATE_W];
        env_lvls[e][k*LVL_W +: LVL_W] =
          cfg_ff[BASE + 4'(2 + k / 4)][(k % 4)*FLD_STRIDE +: LVL_W];
      end
    end
    vem_env u_env (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .ce_i         (ce_i),
      .tick_i       (tick_i),
      .tempo_tick_i (tempo_tick_i),
      .key_on_i     (key_on_i),
      .key_off_i    (key_off_i),
      .rates_i      (env_rates[e]),
      .levels_i     (env_lvls[e]),
      .tempo_mode_i (cfg_ff[BASE + 4'h1][ENV_MODE_BIT]),
      .repeat_i     (cfg_ff[BASE + 4'h1][ENV_REPEAT_BIT]),
      .level_o      (env_lvl[e]),
      .hold_o       (env_hold[e]),
      .stage_o      (env_stage[e])
    );
  end

  // outputs go to routing only
  // The cutoff target is reached only through a modulation_route entry
  assign fenv_o = env_lvl[0];
  assign aenv_o = env_lvl[1];

  for (genvar i = 0; i < NUM_LFO; i++) begin : g_lfo
    logic [31:0]            cfg;
    logic [2:0]             shape;
    logic                   ksync;
    logic signed [7:0]      rate;
    logic signed [7:0]      dly;
    logic [6:0]             vset;
    logic signed [9:0]      idx_s;
    logic signed [9:0]      abs_s;
    logic [4:0]             nidx;
    logic [6:0]             arate;
    logic [4:0]             didx;
    logic                   tmp_rate;
    logic [15:0]            inc_abs;
    logic signed [27:0]     vprod;
    logic [15:0]            inc;
    logic                   step_en;
    logic [PH_W:0]          ph_sum;
    logic [PH_W-1:0]        phase_ff;
    logic signed [7:0]      vrnd_ff;
    logic [15:0]            dcnt_ff;
    logic                   dtmp_ff;
    logic                   act_ff;
    logic [OUT_W-1:0]       hold_rnd_ff;
    logic [OUT_W-1:0]       wave;
    logic [PH_W-2:0]        tri_t;

    assign cfg   = cfg_ff[REG_LFO1 + 4'(i)];
    assign shape = cfg[2:0];
    assign ksync = cfg[LFO_SYNC_BIT];
    assign rate  = signed'(cfg[LFO_RATE_LSB +: 8]);
    assign dly   = signed'(cfg[LFO_DLY_LSB +: 8]);
    assign vset  = cfg[LFO_VAR_LSB +: 7];
    assign tmp_rate = rate[7];

    assign idx_s = -10'(rate) - 10'sd1 + 10'(signed'(rate_mod[i]));
    assign nidx  = (idx_s < 0) ? 5'd0 :
                   (idx_s > 10'(NOTE_LAST)) ? 5'(NOTE_LAST) : 5'(idx_s);
    assign abs_s = 10'(rate) + 10'(signed'(rate_mod[i]));
    assign arate = (abs_s < 0) ? 7'd0 :
                   (abs_s > 10'(LFO_RATE_MAX)) ? 7'(LFO_RATE_MAX) : 7'(abs_s);
    assign inc_abs = 16'(LFO_INC_BASE) + 16'((32'(arate) * 32'(LFO_SLOPE_Q2)) >> 2);

    assign vprod = signed'({1'b0, 11'(inc_abs)}) *
                   signed'({1'b0, (vset > 7'(VAR_MAX)) ? 7'(VAR_MAX) : vset}) * vrnd_ff;
    assign inc = tmp_rate ? NOTE_INC[nidx] :
                 16'(signed'(inc_abs) + 16'(vprod >>> VAR_SHR));
    assign step_en = tmp_rate ? tempo_tick_i : tick_i;
    assign ph_sum  = {1'b0, phase_ff} + {1'b0, inc};

    // Phase: reset or random on press, advance on its tick
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        phase_ff <= '0;
        vrnd_ff  <= '0;
      end else if (ce_i) begin
        if (key_on_i) begin
          phase_ff <= ksync ? '0 : lfsr_ff[i*PH_W +: PH_W];
          vrnd_ff  <= signed'(lfsr_ff[(1-i)*PH_W +: 8]);
        end else if (step_en) begin
          phase_ff <= ph_sum[PH_W-1:0];
        end
      end
    end

    assign didx = (dly < -8'sd25) ? 5'(NOTE_LAST) : 5'(-dly - 8'sd1);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        dcnt_ff <= '0;
        dtmp_ff <= 1'b0;
        act_ff  <= 1'b0;
      end else if (ce_i) begin
        if (key_on_i) begin
          dtmp_ff <= dly[7];
          dcnt_ff <= dly[7] ? NOTE_LEN[didx] : 16'(dly) * 16'(DLY_ABS_TICKS);
          act_ff  <= (dly == 8'sd0);
        end else if (!act_ff && ((dtmp_ff && tempo_tick_i) || (!dtmp_ff && tick_i))) begin
          dcnt_ff <= dcnt_ff - 16'h0001;
          act_ff  <= (dcnt_ff <= 16'h0001);
        end
      end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        hold_rnd_ff <= '0;
      end else if (ce_i && ((step_en && ph_sum[PH_W]) || key_on_i)) begin
        hold_rnd_ff <= lfsr_ff[i*8 +: OUT_W];
      end
    end

    // Waveform shaping from phase
    assign tri_t = phase_ff[PH_W-1] ? ~phase_ff[PH_W-2:0] : phase_ff[PH_W-2:0];
    always_comb begin
      case (shape)
        SHP_SQR:  wave = phase_ff[PH_W-1] ? 16'h8001 : 16'h7FFF;
        SHP_SAWU: wave = phase_ff ^ 16'h8000;
        SHP_SAWD: wave = ~(phase_ff ^ 16'h8000);
        SHP_RND:  wave = hold_rnd_ff;
        SHP_PAT:  wave = {PAT_STEP[phase_ff[PH_W-1 -: 3]], {LVL_FRAC_W{1'b0}}};
        default:  wave = {~tri_t[PH_W-2], tri_t[PH_W-3:0], 1'b0};
      endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        lfo_ff[i] <= '0;
      end else if (ce_i) begin
        lfo_ff[i] <= (act_ff && !key_on_i) ? wave : '0;
      end
    end
    assign lfo_act[i] = act_ff;
  end

  assign lfo1_o = lfo_ff[0];
  assign lfo2_o = lfo_ff[1];
endmodule : vem_voice_mod
`default_nettype wire

// ---- bench/vem_voice_mod_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module vem_voice_mod_chk
  import vem_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             tick_i,
  input  wire logic             tempo_tick_i,
  input  wire logic             key_on_i,
  input  wire logic             key_off_i,
  input  wire logic [3:0]       addr_i,
  input  wire logic             we_i,
  input  wire logic             re_i,
  input  wire logic [31:0]      rdata_o,
  input  wire logic [OUT_W-1:0] fenv_o,
  input  wire logic [OUT_W-1:0] aenv_o,
  input  wire logic [OUT_W-1:0] lfo1_o,
  input  wire logic [OUT_W-1:0] lfo2_o
);
  logic quiet;
  logic quiet_ff;
  logic seen_key_ff;

  // Quiet cycle: nothing taken that could move an envelope level
  assign quiet = ~ce_i | ~(tick_i | tempo_tick_i | key_on_i | key_off_i | we_i);

  // Two quiet cycles in a row allow for one cycle of output latency
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet_ff    <= 1'h1;
      seen_key_ff <= 1'h0;
    end else begin
      quiet_ff <= quiet;
      if (ce_i && key_on_i) seen_key_ff <= 1'h1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_rdata_idle_zero: assert property (ce_i && !re_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  a_unmapped_read_zero: assert property (ce_i && re_i && addr_i > 4'hA |=> rdata_o == 32'h0)
    else $error("unmapped word read back nonzero");
  a_status_upper_zero: assert property (ce_i && re_i && addr_i == REG_STATUS
    |=> rdata_o[31:10] == 22'h0)
    else $error("status spare bits nonzero");
  a_cfg_mask_kept: assert property (ce_i && re_i && addr_i < 4'hA
    |=> (rdata_o & ~CFG_MASK[$past(addr_i)]) == 32'h0)
    else $error("reserved setting bits read back set");
  a_lfo1_onset_quiet: assert property (ce_i && key_on_i |=> lfo1_o == 16'h0)
    else $error("first oscillator not silent after press");
  a_lfo2_onset_quiet: assert property (ce_i && key_on_i |=> lfo2_o == 16'h0)
    else $error("second oscillator not silent after press");
  a_fenv_tick_only: assert property (quiet && quiet_ff |=> $stable(fenv_o))
    else $error("filter envelope moved without a tick");
  a_aenv_tick_only: assert property (quiet && quiet_ff |=> $stable(aenv_o))
    else $error("aux envelope moved without a tick");
  a_freeze_on_hold: assert property (!ce_i |=> $stable(fenv_o) && $stable(lfo1_o)
    && $stable(lfo2_o) && $stable(rdata_o))
    else $error("outputs moved while clock enable low");
  a_silent_before_key: assert property (!seen_key_ff
    |-> fenv_o == 16'h0 && aenv_o == 16'h0 && lfo1_o == 16'h0)
    else $error("output active before any key press");
endmodule : vem_voice_mod_chk

bind vem_voice_mod vem_voice_mod_chk i_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .tick_i(tick_i), .tempo_tick_i(tempo_tick_i),
  .key_on_i(key_on_i), .key_off_i(key_off_i), .addr_i(addr_i), .we_i(we_i), .re_i(re_i),
  .rdata_o(rdata_o), .fenv_o(fenv_o), .aenv_o(aenv_o), .lfo1_o(lfo1_o), .lfo2_o(lfo2_o));
`default_nettype wire

// ---- bench/vem_note_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module vem_note_src (
  input  wire logic clk_i,
  output logic      key_on_o,
  output logic      key_off_o,
  output logic      tick_o,
  output logic      tempo_tick_o
);
  // Idle at time zero so nothing is taken during reset
  initial begin
    key_on_o     = 1'h0;
    key_off_o    = 1'h0;
    tick_o       = 1'h0;
    tempo_tick_o = 1'h0;
  end

  // One-cycle key event; press and release never share a cycle
  task automatic key(input logic press);
    @(posedge clk_i);
    key_on_o  <= press;
    key_off_o <= ~press;
    @(posedge clk_i);
    key_on_o  <= 1'h0;
    key_off_o <= 1'h0;
    @(posedge clk_i);
    #1;
  endtask : key

  // Ticks with an idle cycle between, then one spare cycle to settle
  task automatic ticks(input int n, input logic tempo);
    repeat (n) begin
      @(posedge clk_i);
      if (tempo) tempo_tick_o <= 1'h1;
      else tick_o <= 1'h1;
      @(posedge clk_i);
      tick_o       <= 1'h0;
      tempo_tick_o <= 1'h0;
    end
    @(posedge clk_i);
    #1;
  endtask : ticks
endmodule : vem_note_src
`default_nettype wire

// ---- bench/vem_voice_mod_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module vem_voice_mod_test
  import vem_pkg::*;
;
  logic             clk_i, rst_n_i, ce_i, we_i, re_i;
  logic             key_on_i, key_off_i, tick_i, tempo_tick_i;
  logic [3:0]       addr_i;
  logic [31:0]      wdata_i, rdata_o, d;
  logic [7:0]       mod1, mod2;
  logic [OUT_W-1:0] fenv_o, aenv_o, lfo1_o, lfo2_o;
  int               n_fail = 0;
  int               tests_run = 0;
  logic [15:0]      lv [0:5] = '{16'h4000, 16'h2000, 16'hF000, 16'h1000, 16'hE000, 16'h0800};
  logic [3:0]       st [0:3] = '{4'h3, 4'h2, 4'h6, 4'hE};

  // 200 MHz clock
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end

  vem_note_src i_src (.clk_i(clk_i), .key_on_o(key_on_i), .key_off_o(key_off_i),
    .tick_o(tick_i), .tempo_tick_o(tempo_tick_i));

  vem_voice_mod i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .tick_i(tick_i),
    .tempo_tick_i(tempo_tick_i), .key_on_i(key_on_i), .key_off_i(key_off_i),
    .lfo1_rate_mod_i(mod1), .lfo2_rate_mod_i(mod2), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .fenv_o(fenv_o), .aenv_o(aenv_o),
    .lfo1_o(lfo1_o), .lfo2_o(lfo2_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    we_i    <= 1'h1;
    @(posedge clk_i);
    we_i <= 1'h0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    re_i   <= 1'h1;
    @(posedge clk_i);
    re_i <= 1'h0;
    #1 v = rdata_o;
  endtask : rd

  task automatic end_of_test();
    $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #400000;
    n_fail++;
    end_of_test();
  end

  initial begin
    {rst_n_i, ce_i, we_i, re_i, addr_i, wdata_i, mod1, mod2} = '0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'h1;
    ce_i    <= 1'h1;
    // Reset values, reserved bits and ignored writes to unmapped words
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], d);
      chk(d, (a < 10) ? CFG_RST[a] : 32'h0);
    end
    for (int a = 0; a < 13; a++) wr(a[3:0], 32'hFFFFFFFF);
    for (int a = 0; a < 13; a++) begin
      rd(a[3:0], d);
      chk(d, (a < 10) ? CFG_MASK[a] : 32'h0);
    end
    for (int a = 0; a < 10; a++) wr(a[3:0], 32'h0);
    // Both envelopes get the same contour, two stages negative
    wr(4'h2, 32'h10F02040);
    wr(4'h3, 32'h000008E0);
    wr(4'h6, 32'h10F02040);
    wr(4'h7, 32'h000008E0);
    i_src.key(1'h1);
    rd(REG_STATUS, d);
    chk(d[3:0], 4'h1);
    for (int k = 0; k < 4; k++) begin
      i_src.ticks(2, 1'h0);
      chk(fenv_o, lv[k]);
      chk(aenv_o, lv[k]);
      rd(REG_STATUS, d);
      chk(d[3:0], st[k]);
    end
    i_src.ticks(3, 1'h0);
    chk(fenv_o, lv[3]);
    i_src.key(1'h0);
    rd(REG_STATUS, d);
    chk(d[3:0], 4'h7);
    for (int k = 4; k < 6; k++) begin
      i_src.ticks(2, 1'h0);
      chk(fenv_o, lv[k]);
    end
    i_src.ticks(2, 1'h0);
    chk(fenv_o, lv[5]);
    // Clock enable low freezes the walk, then release in mid-attack
    i_src.key(1'h1);
    @(posedge clk_i) ce_i <= 1'h0;
    i_src.ticks(4, 1'h0);
    @(posedge clk_i) ce_i <= 1'h1;
    rd(REG_STATUS, d);
    chk(d[3:0], 4'h1);
    i_src.ticks(1, 1'h0);
    i_src.key(1'h0);
    rd(REG_STATUS, d);
    chk(d[3:0], 4'h7);
    i_src.ticks(4, 1'h0);
    // Repeat loops back to attack one while held
    wr(4'h1, 32'h00020000);
    i_src.key(1'h1);
    i_src.ticks(8, 1'h0);
    rd(REG_STATUS, d);
    chk(d[3:0], 4'h1);
    i_src.key(1'h0);
    rd(REG_STATUS, d);
    chk(d[3:0], 4'h7);
    i_src.ticks(4, 1'h0);
    // Tempo mode: rate 1 lasts twelve tempo ticks, control ticks ignored
    wr(4'h1, 32'h00010000);
    wr(4'h0, 32'h00000001);
    i_src.key(1'h1);
    i_src.ticks(5, 1'h0);
    i_src.ticks(11, 1'h1);
    rd(REG_STATUS, d);
    chk(d[3:0], 4'h1);
    i_src.ticks(1, 1'h1);
    rd(REG_STATUS, d);
    chk(d[3:0], 4'h3);
    i_src.key(1'h0);
    // Onset delay: absolute 1 is sixteen ticks, note -25 is six tempo ticks
    wr(4'h8, 32'h00010008);
    wr(4'h9, 32'h00E70008);
    mod1 <= 8'h01;
    i_src.key(1'h1);
    i_src.ticks(15, 1'h0);
    i_src.ticks(5, 1'h1);
    rd(REG_STATUS, d);
    chk(d[9:8], 2'h0);
    chk(lfo1_o, 16'h0);
    chk(lfo2_o, 16'h0);
    i_src.ticks(1, 1'h1);
    rd(REG_STATUS, d);
    chk(d[9:8], 2'h2);
    i_src.ticks(1, 1'h0);
    rd(REG_STATUS, d);
    chk(d[9:8], 2'h3);
    // Tempo rates: sync restarts phase, modulation steps one note entry, clamps at the last
    wr(4'h8, 32'h0000FF0D);
    wr(4'h9, 32'h6400FF0A);
    mod1 <= 8'h17;
    mod2 <= 8'h17;
    i_src.key(1'h1);
    chk(lfo2_o, 16'h8000);
    i_src.ticks(2, 1'h1);
    chk(lfo1_o, {PAT_STEP[2], 8'h00});
    chk(lfo2_o, 16'(2 * NOTE_INC[23]) ^ 16'h8000);
    mod2 <= 8'h40;
    i_src.ticks(1, 1'h1);
    chk(lfo1_o, {PAT_STEP[3], 8'h00});
    chk(lfo2_o, 16'(2 * NOTE_INC[23] + NOTE_INC[24]) ^ 16'h8000);
    end_of_test();
  end
endmodule : vem_voice_mod_test
`default_nettype wire
